// File: core/sarseq_pkg.sv
/*
  Shared constants and types for the converter sequence controller.
  Assumes a 100 MHz REF_CLK standing in for the master clock input.
*/
package sarseq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int HW_RESET_MIN_NS = 100;
  localparam int HW_RESET_CYC =
    (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_EXTRA_NS = 235;
  localparam int CONV_EXTRA_CYC =
    (CONV_MAX_EXTRA_NS / CLK_PERIOD_NS) > 0 ? CONV_MAX_EXTRA_NS / CLK_PERIOD_NS : 1;
  localparam int DIV_RATIO = 4;
  localparam int EOT_DELAY_CYC = 15;
  localparam int CONV_MIN_12 = 49;
  localparam int CONV_MIN_14 = 57;
  localparam int CONV_MIN_16 = 65;
  localparam int CAL_CYC_12 = 58280;
  localparam int CAL_CYC_WIDE = 1441020;
  localparam int EOC_READ_CYC = 4;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [20:0] CAL_COUNT_RESET = 21'h00000;

  typedef enum logic [1:0] {
    SARSEQ_CAL = 2'h0,
    SARSEQ_TRACK = 2'h1,
    SARSEQ_SYNC = 2'h2,
    SARSEQ_CONV = 2'h3
  } sarseq_state_type;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_hold_n;
    logic reg_select;
  } sarseq_bus_type;

  typedef struct packed {
    logic cal_req;
    logic background_adjust_n;
  } sarseq_latch_type;
endpackage

// File: core/sarseq_ctrl.sv
/*
  Conversion/calibration sequencer of a self-calibrating SAR converter.
  Assumes all inputs synchronous to REF_CLK; the analog array, comparator
  decision and output bus drivers are outside and reached by plain ports.
*/
`timescale 1ns/1ns
module sarseq_ctrl
  import sarseq_pkg::*;
#(
  parameter int RES_BITS = 16,
  parameter int CAL_CYCLES = (RES_BITS == 12) ? CAL_CYC_12 : CAL_CYC_WIDE
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // hardware reset pin, active high
  input wire logic HW_RESET,
  // host strobes
  input wire sarseq_bus_type BUS,
  // calibration control inputs
  input wire sarseq_latch_type CAL_IN,
  // comparator decision for the bit under trial
  input wire logic COMP_HIGH,
  // outputs
  output logic EOC_N,
  output logic ACQUISITION_DONE_N,
  output logic CONVERTING,
  output logic CALIBRATING,
  output logic TRACKING,
  output logic [RES_BITS-1:0] RESULT,
  output sarseq_latch_type LATCHED
);
  localparam int CONV_MIN = (RES_BITS == 12) ? CONV_MIN_12 :
                            (RES_BITS == 14) ? CONV_MIN_14 : CONV_MIN_16;
  // the strobe edge plus these whole steps give exactly the minimum conversion
  localparam logic [7:0] CONV_STEPS = 8'((CONV_MIN - 1) / DIV_RATIO);
  localparam logic [20:0] CAL_LAST = 21'(CAL_CYCLES - 1);

  typedef struct packed {
    sarseq_state_type st;
    logic [1:0] phase;
    logic [7:0] steps;
    logic [20:0] cal_cnt;
    logic [4:0] eot_cnt;
    logic [2:0] rd_cnt;
    logic rd_pend;
    logic hold_q;
    logic eoc_n;
    logic eot_n;
    logic [RES_BITS-1:0] sar;
    logic [RES_BITS-1:0] result;
    sarseq_latch_type lat;
  } sarseq_regs_type;

  sarseq_regs_type r_q, r_d;
  logic tick, hold_fall, soft_reset, standalone, data_read;

  // internal step enable: every fourth master clock
  assign tick = (r_q.phase == 2'(DIV_RATIO - 1));
  assign hold_fall = r_q.hold_q & ~BUS.wr_hold_n;
  assign soft_reset = ~BUS.cs_n & ~BUS.reg_select & ~BUS.wr_hold_n;
  assign standalone = ~BUS.cs_n & ~BUS.rd_n & BUS.reg_select;
  assign data_read = ~BUS.cs_n & ~BUS.rd_n & BUS.reg_select;

  // next-state logic; any reset source wins over state, phase, cal and eot counts, eoc, eot and read pending; other loads stand
  always_comb begin
    r_d = r_q;
    r_d.hold_q = BUS.wr_hold_n;
    r_d.phase = r_q.phase + 2'h1;
    // transparent while chip select is low; the rise of chip select freezes them
    if (~BUS.cs_n) begin
      r_d.lat = CAL_IN;
    end
    // end-of-track countdown after end of conversion falls
    if (r_q.eot_cnt != 5'h00) begin
      r_d.eot_cnt = r_q.eot_cnt - 5'h01;
      if (r_q.eot_cnt == 5'h01) begin
        r_d.eot_n = 1'b0;
      end
    end
    // end of conversion returns high a few cycles after a data read
    if (r_q.rd_pend) begin
      r_d.rd_cnt = r_q.rd_cnt + 3'h1;
      if (r_q.rd_cnt == 3'(EOC_READ_CYC - 1)) begin
        r_d.eoc_n = 1'b1;
        r_d.rd_pend = 1'b0;
      end
    end else if (data_read & ~r_q.eoc_n & (r_q.st == SARSEQ_TRACK)) begin
      r_d.rd_pend = 1'b1;
      r_d.rd_cnt = 3'h0;
    end
    case (r_q.st)
      SARSEQ_CAL: begin
        // hold is ignored here
        r_d.eoc_n = 1'b1;
        r_d.cal_cnt = r_q.cal_cnt + 21'h00001;
        if (r_q.cal_cnt == CAL_LAST) begin
          r_d.st = SARSEQ_TRACK;
          r_d.eot_cnt = 5'(EOT_DELAY_CYC);
          r_d.eot_n = 1'b1;
          // standalone wide parts keep end of conversion high
          r_d.eoc_n = (standalone && RES_BITS != 12) ? 1'b1 : 1'b0;
        end
      end
      SARSEQ_TRACK: begin
        if (hold_fall) begin
          // a strobe already on the internal step, as in loopback, starts at once
          r_d.st = tick ? SARSEQ_CONV : SARSEQ_SYNC; // charge trapped now
          r_d.steps = 8'h00;
          r_d.sar = '0;
          r_d.sar[RES_BITS-1] = 1'b1;
          r_d.eoc_n = 1'b1;
          r_d.rd_pend = 1'b0;
          r_d.eot_n = 1'b1;
          r_d.eot_cnt = 5'h00;
        end
      end
      SARSEQ_SYNC: begin
        // start waits for the next internal step
        if (tick) begin
          r_d.st = SARSEQ_CONV;
          r_d.steps = 8'h00;
          r_d.sar = '0;
          r_d.sar[RES_BITS-1] = 1'b1;
        end
      end
      SARSEQ_CONV: begin
        if (tick) begin
          r_d.steps = r_q.steps + 8'h01;
          if (r_q.steps < 8'(RES_BITS)) begin
            // decide one bit, trial the next lower
            for (int i = 0; i < RES_BITS; i++) begin
              if (r_q.steps == 8'(RES_BITS - 1 - i)) begin
                r_d.sar[i] = COMP_HIGH;
              end else if (r_q.steps == 8'(RES_BITS - 2 - i)) begin
                r_d.sar[i] = 1'b1;
              end
            end
          end
          if (r_q.steps == CONV_STEPS - 8'h01) begin
            r_d.st = SARSEQ_TRACK;
            // the last bit is decided on this very step, so take the new word
            r_d.result = r_d.sar;
            r_d.eoc_n = 1'b0;
            r_d.eot_cnt = 5'(EOT_DELAY_CYC); // aligned to tick
          end
        end
      end
      default: r_d.st = SARSEQ_CAL;
    endcase
    // reset overrides conversion and calibration alike
    if (HW_RESET | soft_reset) begin
      r_d.st = SARSEQ_CAL;
      r_d.cal_cnt = CAL_COUNT_RESET;
      r_d.eoc_n = 1'b1;
      r_d.eot_n = 1'b1;
      r_d.eot_cnt = 5'h00;
      r_d.rd_pend = 1'b0;
      r_d.phase = PHASE_RESET;
    end
  end

  // state register; cold reset also lands in calibration
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      r_q <= '0;
      r_q.st <= SARSEQ_CAL;
      r_q.eoc_n <= 1'b1;
      r_q.eot_n <= 1'b1;
      r_q.hold_q <= 1'b1;
      r_q.lat <= 2'h1;
    end else begin
      r_q <= r_d;
    end
  end

  assign EOC_N = r_q.eoc_n;
  assign ACQUISITION_DONE_N = r_q.eot_n;
  assign CONVERTING = (r_q.st == SARSEQ_CONV) | (r_q.st == SARSEQ_SYNC);
  assign CALIBRATING = (r_q.st == SARSEQ_CAL);
  assign TRACKING = (r_q.st == SARSEQ_TRACK);
  assign RESULT = r_q.result;
  assign LATCHED = r_q.lat;

  // checks
  chk_eoc_cal_high: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    CALIBRATING |-> EOC_N) else $error("eoc low in calibration");
  chk_hw_reset_cal: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    HW_RESET |=> CALIBRATING) else $error("reset did not calibrate");
  chk_soft_reset: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    soft_reset |=> CALIBRATING && EOC_N) else $error("soft reset missed");
  chk_eot_delay: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    ($fell(EOC_N) && !HW_RESET && !soft_reset) ##1 (!hold_fall && !HW_RESET && !soft_reset)[*8]
    |-> ACQUISITION_DONE_N) else $error("end of track early");
  chk_hold_start: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (TRACKING && hold_fall && !HW_RESET && !soft_reset) |=> CONVERTING && EOC_N)
    else $error("hold did not start");
  chk_sync_lag: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (r_q.st == SARSEQ_SYNC && !HW_RESET && !soft_reset) |-> ##[1:4] (r_q.st != SARSEQ_SYNC))
    else $error("start lag too long");
  chk_div_four: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    tick |=> !tick ##1 !tick ##1 !tick) else $error("divider wrong");
  chk_latch_close: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    ($rose(BUS.cs_n) && !HW_RESET) |=> LATCHED == $past(CAL_IN, 2)) else $error("latch");
  chk_result_load: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    ($past(CONVERTING) && $fell(EOC_N))
    |-> RESULT == {$past(r_q.sar[RES_BITS-1:1]), $past(COMP_HIGH)}) else $error("result");
  chk_read_eoc: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (TRACKING && !EOC_N && data_read && !r_q.rd_pend && !HW_RESET && !soft_reset)
    |-> ##[1:5] EOC_N) else $error("eoc not raised after read");
  cov_conversion: cover property (@(posedge REF_CLK) $fell(EOC_N) && TRACKING);
  cov_cal_done: cover property (@(posedge REF_CLK) $fell(CALIBRATING));
  cov_eot: cover property (@(posedge REF_CLK) $fell(ACQUISITION_DONE_N));
endmodule

// File: bench/sarseq_host.sv
/*
  Host model: drives chip select, strobes and the calibration inputs.
  Assumes REF_CLK from the bench; it changes lines only at falling edges.
*/
`timescale 1ns/1ns
module sarseq_host
  import sarseq_pkg::*;
(
  // clock
  input wire logic REF_CLK,
  // end of track, looped back to the hold strobe
  input wire logic ACQUISITION_DONE_N,
  // host side of the bus
  output sarseq_bus_type BUS,
  output sarseq_latch_type CAL_IN
);
  // six cycles plus 2.25 us of acquisition at 10 ns
  localparam int ACQ_CYC = 6 + 225;
  // idle bus deselected, interleave off
  initial begin
    BUS = 4'hF;
    CAL_IN = 2'h1;
  end
  // one access; strobe kept two cycles, far below the minimum conversion
  task automatic access(input logic [3:0] b, input logic [1:0] cal);
    @(negedge REF_CLK);
    CAL_IN = cal;
    BUS = b;
    repeat (2) @(negedge REF_CLK);
    // inputs return to idle as chip select rises; the latches must keep the old
    BUS = 4'hF;
    CAL_IN = 2'h1;
  endtask
  // loopback sampling: hold follows end of track, chip select stays high
  task automatic loopback(input int cycles);
    repeat (cycles) begin
      @(negedge REF_CLK);
      BUS.wr_hold_n = ACQUISITION_DONE_N;
    end
    @(negedge REF_CLK);
    BUS = 4'hF;
  endtask
  // wait out acquisition before the next hold strobe
  task automatic acquire();
    repeat (ACQ_CYC) @(negedge REF_CLK);
  endtask
endmodule

// File: bench/sarseq_ctrl_tb.sv
/*
  Testbench of the sequencer: calibration, conversions, reads, resets.
  Assumes the 12-bit build with calibration shortened to 50 cycles, plus a
  14-bit build hard-wired for standalone operation.
*/
`timescale 1ns/1ns
module sarseq_ctrl_tb
  import sarseq_pkg::*;
;
  localparam int CAL_SHORT = 50;
  logic ref_clk = 1'b0;
  logic eoc_w, acq_w;
  logic reset_n = 1'b0;
  logic hw_reset = 1'b0;
  logic comp_high = 1'b0;
  sarseq_bus_type bus;
  sarseq_latch_type cal_in;
  logic eoc_n, acq_n, conv, cal, trk;
  logic [11:0] result;
  sarseq_latch_type latched;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  // clock, 10 ns period
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  sarseq_ctrl #(.RES_BITS(12), .CAL_CYCLES(CAL_SHORT)) uut (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .HW_RESET(hw_reset), .BUS(bus),
    .CAL_IN(cal_in), .COMP_HIGH(comp_high), .EOC_N(eoc_n),
    .ACQUISITION_DONE_N(acq_n), .CONVERTING(conv), .CALIBRATING(cal),
    .TRACKING(trk), .RESULT(result), .LATCHED(latched)
  );
  // standalone wide part: chip select and read tied low, reg_select high
  sarseq_ctrl #(.RES_BITS(14), .CAL_CYCLES(CAL_SHORT)) uut_wide (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .HW_RESET(hw_reset), .BUS(4'h3),
    .CAL_IN(2'h1), .COMP_HIGH(1'b0), .EOC_N(eoc_w),
    .ACQUISITION_DONE_N(acq_w), .CONVERTING(), .CALIBRATING(),
    .TRACKING(), .RESULT(), .LATCHED()
  );
  sarseq_host host (
    .REF_CLK(ref_clk), .ACQUISITION_DONE_N(acq_n), .BUS(bus), .CAL_IN(cal_in)
  );
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // cycles until end of conversion falls, bounded so a hang cannot stall
  task automatic wait_eoc(input int lim, output int cyc);
    cyc = 0;
    while (eoc_n !== 1'b0 && cyc < lim) begin
      @(negedge ref_clk);
      cyc++;
    end
  endtask
  // one conversion with a fixed comparator answer
  task automatic convert(input logic c, input logic [11:0] exp);
    comp_high = c;
    host.access(4'h5, 2'h1);
    check(16'(conv), 16'h0001);
    wait_eoc(100, n);
    check(16'(n + 2 >= CONV_MIN_12 &&
      n + 2 <= CONV_MIN_12 + DIV_RATIO + CONV_EXTRA_CYC), 16'h0001);
    check(16'(result), 16'(exp));
    check(16'(trk), 16'h0001);
    repeat (14) @(negedge ref_clk);
    check(16'(acq_n), 16'h0001);
    @(negedge ref_clk);
    check(16'(acq_n), 16'h0000);
  endtask
  task automatic print_verdict();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    check(16'({cal, eoc_n}), 16'h0003);
    host.access(4'h5, 2'h1);
    check(16'(conv), 16'h0000);
    wait_eoc(100, n);
    check(16'(n >= 40 && n < 100 && !cal), 16'h0001);
    check(16'(eoc_w), 16'h0001);
    repeat (14) @(negedge ref_clk);
    check(16'({eoc_w, acq_w}), 16'h0003);
    @(negedge ref_clk);
    check(16'({eoc_w, acq_w}), 16'h0002);
    host.acquire();
    convert(1'b1, 12'hFFF);
    host.access(4'h3, 2'h1);
    repeat (3) @(negedge ref_clk);
    check(16'(eoc_n), 16'h0001);
    host.acquire();
    convert(1'b0, 12'h000);
    host.acquire();
    // a new start must also raise end of conversion
    host.access(4'h5, 2'h1);
    repeat (3) @(negedge ref_clk);
    check(16'(eoc_n), 16'h0001);
    // software reset in mid-conversion aborts and recalibrates
    host.access(4'h4, 2'h1);
    check(16'({cal, conv, eoc_n}), 16'h0005);
    wait_eoc(100, n);
    check(16'(n < 100), 16'h0001);
    host.acquire();
    // latches hold what was seen when chip select rose
    host.access(4'h3, 2'h0);
    host.access(4'hF, 2'h1);
    check(16'(latched), 16'h0000);
    host.access(4'h3, 2'h1);
    check(16'(latched), 16'h0001);
    // hardware reset pin for 100 ns
    hw_reset = 1'b1; // calibration only ever through reset
    repeat (HW_RESET_CYC) @(negedge ref_clk);
    hw_reset = 1'b0;
    @(negedge ref_clk);
    check(16'({cal, eoc_n}), 16'h0003);
    wait_eoc(100, n);
    check(16'(n + 1), 16'(CAL_SHORT));
    host.acquire();
    convert(1'b1, 12'hFFF);
    // loopback: end of track drives hold; after the first, samples every 64 cycles
    fork
      host.loopback(150);
      begin
        repeat (2) @(negedge ref_clk);
        wait_eoc(100, n);
        repeat (20) @(negedge ref_clk);
        wait_eoc(100, n);
        check(16'(n + 20), 16'(CONV_MIN_12 + EOT_DELAY_CYC));
      end
    join
    print_verdict();
  end
endmodule
